// File: pll_ctrl_map.svh
// Constants for the PLL lock, divider and bypass control block.
// Assumes inclusion by bare name from design files on one system clock.
`ifndef PLL_CTRL_MAP_SVH
`define PLL_CTRL_MAP_SVH

// Register offsets (byte addresses, word aligned)
`define ADDR_CTRL 8'h00
`define ADDR_LOCKCFG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_IRQ_STAT 8'h0c
`define ADDR_IRQ_MASK 8'h10
`define ADDR_SKEW 8'h14

// Control register fields
`define CTRL_BYPASS_BIT 0
`define CTRL_LOCK_POL_BIT 1
`define CTRL_COARSE_BIT 2
`define CTRL_EXT_FB_BIT 3
`define CTRL_BYP_PIN_EN_BIT 4
`define CTRL_PLL_RST_BIT 5
`define CTRL_FB_SEL_LSB 8
`define CTRL_LOCK_PIN_LSB 12
`define CTRL_RESET 32'h0000_0000

// Lock count limits
`define LOCK_CNT_MIN 9'h010
`define LOCK_CNT_MAX 9'h100
`define LOCK_CNT_RESET 9'h010

// Interrupt bits
`define IRQ_LOCK_GAINED 0
`define IRQ_LOCK_LOST 1

// Skew fields
`define SKEW_PHASE_LSB 0
`define SKEW_TIME_LSB 4
`define SKEW_RESET 8'h00

`define NUM_USER_PINS 4
`define NUM_DIVIDERS 4

`endif

// File: pll_ctrl_pkg.sv
// Types shared by the PLL control block and its helpers.
// Assumes the constants header supplies the numeric values.
package pll_ctrl_pkg;

	// Control bits seen by the divider bank and lock logic
	typedef struct packed {
		logic [1:0] lock_pin_sel;
		logic [1:0] fb_sel;
		logic pll_rst;
		logic byp_pin_en;
		logic ext_fb;
		logic coarse;
		logic lock_pol;
		logic bypass_sw;
	} ctrl_t;

	// Feedback skew settings after mode gating
	typedef struct packed {
		logic [3:0] time_skew;
		logic [3:0] phase_skew;
	} skew_t;

	typedef enum logic [2:0] {
		LK_IDLE = 3'b001,
		LK_COUNT = 3'b010,
		LK_LOCKED = 3'b100
	} lock_state_t;

endpackage : pll_ctrl_pkg

// File: lock_qualifier.sv
// Lock qualifier: counts consecutive good compare cycles before declaring lock.
// Assumes raw_lock_in is already synchronous to clk_sys_in.
`timescale 1ns/10ps

module lock_qualifier (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic raw_lock_in,
	input wire logic [8:0] need_cnt_in,
	output logic locked_out
);

	pll_ctrl_pkg::lock_state_t state_r;
	logic [8:0] cnt_r;

	// ==========================================================
	// Qualification state machine
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || clear_in) begin
			state_r <= pll_ctrl_pkg::LK_IDLE;
			cnt_r <= 9'h000;
		end else begin
			case (state_r)
				pll_ctrl_pkg::LK_IDLE: begin
					cnt_r <= 9'h000;
					if (raw_lock_in) begin
						state_r <= pll_ctrl_pkg::LK_COUNT;
						cnt_r <= 9'h001;
					end
				end
				pll_ctrl_pkg::LK_COUNT: begin
					if (!raw_lock_in) begin
						state_r <= pll_ctrl_pkg::LK_IDLE;
						cnt_r <= 9'h000;
					end else if (cnt_r >= need_cnt_in) begin
						state_r <= pll_ctrl_pkg::LK_LOCKED;
					end else begin
						cnt_r <= cnt_r + 9'h001;
					end
				end
				pll_ctrl_pkg::LK_LOCKED: begin
					if (!raw_lock_in) begin
						state_r <= pll_ctrl_pkg::LK_IDLE;
						cnt_r <= 9'h000;
					end
				end
				default: begin
					state_r <= pll_ctrl_pkg::LK_IDLE;
					cnt_r <= 9'h000;
				end
			endcase
		end
	end

	// Loss drops lock combinationally so no qualifying delay applies
	assign locked_out = (state_r == pll_ctrl_pkg::LK_LOCKED) && raw_lock_in && !clear_in;

endmodule : lock_qualifier

// File: pll_ctrl_top.sv
// Top of the PLL digital control: register port, lock detect, divider bank,
// bypass and feedback selection, interrupts.
// Assumes the VCO, reference and raw phase-detector lock arrive as inputs
// sampled on clk_sys_in; pins are synchronised here.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

`include "pll_ctrl_map.svh"

// Notes on behaviour
// - Lock indicator asserts while locked; its active level is configurable.
// - Frequency-lock qualification count is programmable from 16 to 256.
// - Lock indicator drops at once when lock is lost.
// - Lock indicator can be routed to any one user pin.
// - Normal skew mode: dividers are 2, 4, 8 and 16.
// - Coarse skew mode: dividers are 4, 8, 16 and 32.
// - Feedback may come from any divider; output equals ref times Vfb over Vk.
// - Bypass feeds the reference straight into the dividers instead of the VCO.
// - During bypass, lock detect and phase skew are unavailable.
// - Bypass is driven by the management register or by a user pin.
// - Feedback path is selectable as internal or external.
// - Internal feedback frees all outputs; only phase skew on feedback.
// - External feedback allows both phase and time skew on feedback.
module pll_ctrl_top (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic vco_clk_in,
	input wire logic ref_clk_in,
	input wire logic raw_lock_in,
	input wire logic fb_return_in,
	input wire logic bypass_pin_in,
	output logic [31:0] rdata_out,
	output logic irq_out,
	output logic [3:0] user_pin_out,
	output logic [3:0] div_clk_out,
	output logic fb_clk_out,
	output logic fb_is_ext_out,
	output logic [7:0] fb_skew_out,
	output logic bypass_out
);

	// ==========================================================
	// Software-visible state
	pll_ctrl_pkg::ctrl_t ctrl_r;
	logic [8:0] lock_cnt_r;
	logic [7:0] skew_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic [31:0] rdata_r;

	// Pin synchronisers
	logic byp_pin_s1_r;
	logic byp_pin_s2_r;
	logic raw_lock_s1_r;
	logic raw_lock_s2_r;
	logic fb_ret_s1_r;
	logic fb_ret_s2_r;
	// Divider sources run on other clocks, so they are retimed as well
	logic vco_s1_r;
	logic vco_s2_r;
	logic ref_s1_r;
	logic ref_s2_r;

	// Internal
	logic bypass_now;
	logic bypass_prev_r;
	logic lock_clear;
	logic locked;
	logic locked_prev_r;
	logic lock_ind;
	logic div_src;
	logic [3:0] div_clk;
	logic fb_clk;
	pll_ctrl_pkg::skew_t fb_skew;

	logic [3:0] user_pin_r;
	logic [3:0] div_clk_r;
	logic fb_clk_r;
	logic fb_is_ext_r;
	logic [7:0] fb_skew_r;
	logic bypass_r;
	logic irq_r;

	// Clamp a requested count into the allowed lock window
	function automatic logic [8:0] clamp_cnt(input logic [31:0] v);
		if (v < {23'h000000, `LOCK_CNT_MIN})
			clamp_cnt = `LOCK_CNT_MIN;
		else if (v > {23'h000000, `LOCK_CNT_MAX})
			clamp_cnt = `LOCK_CNT_MAX;
		else
			clamp_cnt = v[8:0];
	endfunction : clamp_cnt

	// ==========================================================
	// Two-stage synchronisers for pin and analog-side inputs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			byp_pin_s1_r <= 1'b0;
			byp_pin_s2_r <= 1'b0;
			raw_lock_s1_r <= 1'b0;
			raw_lock_s2_r <= 1'b0;
			fb_ret_s1_r <= 1'b0;
			fb_ret_s2_r <= 1'b0;
			vco_s1_r <= 1'b0;
			vco_s2_r <= 1'b0;
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
		end else begin
			byp_pin_s1_r <= bypass_pin_in;
			byp_pin_s2_r <= byp_pin_s1_r;
			raw_lock_s1_r <= raw_lock_in;
			raw_lock_s2_r <= raw_lock_s1_r;
			fb_ret_s1_r <= fb_return_in;
			fb_ret_s2_r <= fb_ret_s1_r;
			vco_s1_r <= vco_clk_in;
			vco_s2_r <= vco_s1_r;
			ref_s1_r <= ref_clk_in;
			ref_s2_r <= ref_s1_r;
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ctrl_r <= pll_ctrl_pkg::ctrl_t'(`CTRL_RESET);
			lock_cnt_r <= `LOCK_CNT_RESET;
			skew_r <= `SKEW_RESET;
			irq_mask_r <= 2'h0;
		end else if (wr_in) begin
			case (addr_in)
				`ADDR_CTRL: begin
					ctrl_r.bypass_sw <= wdata_in[`CTRL_BYPASS_BIT];
					ctrl_r.lock_pol <= wdata_in[`CTRL_LOCK_POL_BIT];
					ctrl_r.coarse <= wdata_in[`CTRL_COARSE_BIT];
					ctrl_r.ext_fb <= wdata_in[`CTRL_EXT_FB_BIT];
					ctrl_r.byp_pin_en <= wdata_in[`CTRL_BYP_PIN_EN_BIT];
					ctrl_r.pll_rst <= wdata_in[`CTRL_PLL_RST_BIT];
					ctrl_r.fb_sel <= wdata_in[`CTRL_FB_SEL_LSB +: 2];
					ctrl_r.lock_pin_sel <= wdata_in[`CTRL_LOCK_PIN_LSB +: 2];
				end
				`ADDR_LOCKCFG: lock_cnt_r <= clamp_cnt(wdata_in);
				`ADDR_IRQ_MASK: irq_mask_r <= wdata_in[1:0];
				`ADDR_SKEW: skew_r <= wdata_in[7:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Bypass source: pin when enabled, otherwise register
	assign bypass_now = ctrl_r.byp_pin_en ? byp_pin_s2_r : ctrl_r.bypass_sw;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			bypass_prev_r <= 1'b0;
		else
			bypass_prev_r <= bypass_now;
	end

	// Counter is held clear for the whole of bypass and while PLL reset is set; lock loss is inside
	assign lock_clear = ctrl_r.pll_rst || (bypass_now && !bypass_prev_r) || bypass_now;

	lock_qualifier u_lockq (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.clear_in(lock_clear),
		.raw_lock_in(raw_lock_s2_r),
		.need_cnt_in(lock_cnt_r),
		.locked_out(locked)
	);

	// Polarity applied last so the inactive level follows the setting too
	assign lock_ind = locked ^ ctrl_r.lock_pol;

	// ==========================================================
	// Divider bank; reference replaces VCO in bypass
	assign div_src = bypass_now ? ref_s2_r : vco_s2_r;

	div_bank u_divs (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.src_in(div_src),
		.coarse_in(ctrl_r.coarse),
		.div_out(div_clk)
	);

	// Feedback from any divider, or from the external return
	assign fb_clk = ctrl_r.ext_fb ? fb_ret_s2_r : div_clk[ctrl_r.fb_sel];

	// Skew gating by feedback mode and bypass
	always_comb begin
		fb_skew.phase_skew = bypass_now ? 4'h0 : skew_r[`SKEW_PHASE_LSB +: 4];
		fb_skew.time_skew = ctrl_r.ext_fb ? skew_r[`SKEW_TIME_LSB +: 4] : 4'h0;
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			user_pin_r <= 4'h0;
			div_clk_r <= 4'h0;
			fb_clk_r <= 1'b0;
			fb_is_ext_r <= 1'b0;
			fb_skew_r <= 8'h00;
			bypass_r <= 1'b0;
		end else begin
			// Unselected pins idle at the inactive lock level
			for (int i = 0; i < `NUM_USER_PINS; i++) begin
				user_pin_r[i] <= (ctrl_r.lock_pin_sel == i[1:0]) ? lock_ind : ctrl_r.lock_pol;
			end
			div_clk_r <= div_clk;
			fb_clk_r <= fb_clk;
			fb_is_ext_r <= ctrl_r.ext_fb;
			fb_skew_r <= fb_skew;
			bypass_r <= bypass_now;
		end
	end

	// ==========================================================
	// Interrupts: sticky, write-one-to-clear, set wins over clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			locked_prev_r <= 1'b0;
		else
			locked_prev_r <= locked;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_stat_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_in && addr_in == `ADDR_IRQ_STAT && wdata_in[i])
					irq_stat_r[i] <= 1'b0;
			end
			if (locked && !locked_prev_r)
				irq_stat_r[`IRQ_LOCK_GAINED] <= 1'b1;
			if (!locked && locked_prev_r)
				irq_stat_r[`IRQ_LOCK_LOST] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			irq_r <= 1'b0;
		else
			irq_r <= |(irq_stat_r & irq_mask_r);
	end

	// ==========================================================
	// Read port, data valid the cycle after the strobe only
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd_in) begin
			case (addr_in)
				`ADDR_CTRL: rdata_r <= {16'h0000, 2'h0, ctrl_r.lock_pin_sel, 2'h0,
					ctrl_r.fb_sel, 2'h0, ctrl_r.pll_rst, ctrl_r.byp_pin_en,
					ctrl_r.ext_fb, ctrl_r.coarse, ctrl_r.lock_pol, ctrl_r.bypass_sw};
				`ADDR_LOCKCFG: rdata_r <= {23'h000000, lock_cnt_r};
				`ADDR_STATUS: rdata_r <= {29'h00000000, ctrl_r.ext_fb, bypass_now, locked};
				`ADDR_IRQ_STAT: rdata_r <= {30'h00000000, irq_stat_r};
				`ADDR_IRQ_MASK: rdata_r <= {30'h00000000, irq_mask_r};
				`ADDR_SKEW: rdata_r <= {24'h000000, skew_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	assign rdata_out = rdata_r;
	assign irq_out = irq_r;
	assign user_pin_out = user_pin_r;
	assign div_clk_out = div_clk_r;
	assign fb_clk_out = fb_clk_r;
	assign fb_is_ext_out = fb_is_ext_r;
	assign fb_skew_out = fb_skew_r;
	assign bypass_out = bypass_r;

	// ==========================================================
	// Checks
	property p_lock_drop;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!raw_lock_s2_r |-> !locked;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock held without raw lock");

	property p_lock_pol;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(ctrl_r.lock_pin_sel == 2'h0) |=> user_pin_out[0] == ($past(locked) ^ $past(ctrl_r.lock_pol));
	endproperty
	a_lock_pol: assert property (p_lock_pol) else $error("lock pin level wrong");

	property p_byp_nolock;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bypass_now |-> !locked;
	endproperty
	a_byp_nolock: assert property (p_byp_nolock) else $error("lock seen in bypass");

	property p_byp_phase;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bypass_now |=> fb_skew_out[3:0] == 4'h0;
	endproperty
	a_byp_phase: assert property (p_byp_phase) else $error("phase skew in bypass");

	property p_int_time;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!ctrl_r.ext_fb |=> fb_skew_out[7:4] == 4'h0 && !fb_is_ext_out;
	endproperty
	a_int_time: assert property (p_int_time) else $error("time skew on internal feedback");

	property p_ext_time;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		ctrl_r.ext_fb |=> fb_skew_out[7:4] == $past(skew_r[7:4]);
	endproperty
	a_ext_time: assert property (p_ext_time) else $error("time skew lost on external feedback");

	property p_min_cnt;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(locked) |-> $past(raw_lock_s2_r, 16);
	endproperty
	a_min_cnt: assert property (p_min_cnt) else $error("lock asserted too soon");

	property p_byp_src;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bypass_now |-> div_src == $past(ref_s1_r);
	endproperty
	a_byp_src: assert property (p_byp_src) else $error("dividers not on reference");

	property p_fb_sel;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!ctrl_r.ext_fb |=> {3'h0, fb_clk_out} == (($past(div_clk) >> $past(ctrl_r.fb_sel)) & 4'h1);
	endproperty
	a_fb_sel: assert property (p_fb_sel) else $error("feedback divider wrong");

	// Any clear leaves the qualifier idle, so no lock survives it
	property p_clear_nolock;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		lock_clear |=> !locked;
	endproperty
	a_clear_nolock: assert property (p_clear_nolock) else $error("lock kept after clear");

endmodule : pll_ctrl_top

// File: div_bank.sv
// Four post-VCO dividers as a ripple of toggle stages, sampled on clk_sys_in.
// Assumes src_in toggles slower than half the system clock in simulation.
`timescale 1ns/10ps

module div_bank (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic src_in,
	input wire logic coarse_in,
	output logic [3:0] div_out
);

	logic src_d_r;
	logic [4:0] cnt_r;

	// Count source rising edges; bit k toggles at source over 2^(k+1)
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			src_d_r <= 1'b0;
			cnt_r <= 5'h00;
		end else begin
			src_d_r <= src_in;
			if (src_in && !src_d_r)
				cnt_r <= cnt_r + 5'h01;
		end
	end

	// Coarse mode shifts every tap one stage down
	assign div_out = coarse_in ? cnt_r[4:1] : cnt_r[3:0];

endmodule : div_bank

// File: ref_clock_source.sv
// External reference clock source, VCO stand-in and bypass user pin driver.
// Assumes the system clock paces every change; half periods count in sys cycles.
`timescale 1ns/10ps

module ref_clock_source #(
	parameter int REF_HALF = 2,
	parameter int VCO_HALF = 3
) (
	input wire logic clk_sys_in,
	input wire logic bypass_req_in,
	output logic ref_clk_out,
	output logic vco_clk_out,
	output logic bypass_pin_out
);
	int ref_cnt = 0;
	int vco_cnt = 0;

	// ==========================================
	// Free-running clocks
	// No reset: a crystal source runs whatever the device does
	initial begin
		ref_clk_out = 1'h0;
		vco_clk_out = 1'h0;
		bypass_pin_out = 1'h0;
	end

	// Square waves, slow enough for the sampled dividers
	always @(posedge clk_sys_in) begin
		ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
		vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
		if (ref_cnt == REF_HALF - 1) begin
			ref_clk_out <= ~ref_clk_out;
		end
		if (vco_cnt == VCO_HALF - 1) begin
			vco_clk_out <= ~vco_clk_out;
		end
	end

	// ==========================================
	// User pin
	// Pin level follows the request one cycle later, as a board driver would
	always @(posedge clk_sys_in) begin
		bypass_pin_out <= bypass_req_in;
	end
endmodule : ref_clock_source

// File: test_pll_ctrl_top.sv
// Self-checking bench for the PLL control block beside a reference source model.
// Assumes the constants header map and one 25 MHz system clock.
`timescale 1ns/10ps
`include "pll_ctrl_map.svh"

module test_pll_ctrl_top;
	logic clk_sys_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'h0;
	logic rd_in = 1'h0;
	logic raw_lock_in = 1'h0;
	logic bypass_req = 1'h0;
	logic vco_clk, ref_clk, bypass_pin, irq_out, fb_clk_out, fb_is_ext_out, bypass_out;
	logic [31:0] rdata_out, got;
	logic [3:0] user_pin_out, div_clk_out, pin_exp;
	logic [7:0] fb_skew_out;
	logic [6:0] watch_r = 7'h00;
	wire logic [6:0] watch = {fb_clk_out, div_clk_out, vco_clk, ref_clk};
	int edge_cnt [7] = '{default: 0};
	int base [7];
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int m_ctrl, m_cfg, m_irq, m_mask, m_skew, t0, r, src, byp, ext;
	int cfg_tab [8] = '{5, 16, 300, 0, 16, 256, 0, 17};
	logic [7:0] rst_addr [7] = '{`ADDR_CTRL, `ADDR_LOCKCFG, `ADDR_STATUS, `ADDR_IRQ_STAT,
		`ADDR_IRQ_MASK, `ADDR_SKEW, 8'h3c};
	logic [31:0] rst_exp [7] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	ref_clock_source u_ref_clock_source (.clk_sys_in(clk_sys_in), .bypass_req_in(bypass_req),
		.ref_clk_out(ref_clk), .vco_clk_out(vco_clk), .bypass_pin_out(bypass_pin));
	pll_ctrl_top u_pll_ctrl_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.vco_clk_in(vco_clk), .ref_clk_in(ref_clk), .raw_lock_in(raw_lock_in),
		.fb_return_in(ref_clk), .bypass_pin_in(bypass_pin), .rdata_out(rdata_out),
		.irq_out(irq_out), .user_pin_out(user_pin_out), .div_clk_out(div_clk_out),
		.fb_clk_out(fb_clk_out), .fb_is_ext_out(fb_is_ext_out), .fb_skew_out(fb_skew_out),
		.bypass_out(bypass_out));

	// ==========================================
	// Clock and edge counters
	initial begin
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// Sampled edge counts; a window ratio tolerates the ripple lag of each tap
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		watch_r <= watch;
		for (int i = 0; i < 7; i++) begin
			if (watch[i] === 1'h1 && watch_r[i] === 1'h0) begin
				edge_cnt[i] <= edge_cnt[i] + 1;
			end
		end
	end

	// ==========================================
	// Compare and bus tasks
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_word

	task automatic check_range(input string what, input int lo, input int hi, input int seen);
		samples_checked++;
		if (seen < lo || seen > hi) begin
			miscompares++;
			$display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, seen);
		end
	endtask : check_range

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'h1;
		@(posedge clk_sys_in);
		wr_in <= 1'h0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'h1;
		@(posedge clk_sys_in);
		rd_in <= 1'h0;
		#1;
		d = rdata_out;
	endtask : reg_rd

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
		reg_rd(a, got);
		check_word(what, exp, got);
	endtask : rd_check

	task automatic set_ctrl(input int v);
		m_ctrl = v;
		reg_wr(`ADDR_CTRL, v);
	endtask : set_ctrl

	task automatic irq_check();
		check_word("irq line", {31'h0, (m_irq & m_mask) != 0}, {31'h0, irq_out});
		rd_check(`ADDR_IRQ_STAT, m_irq, "irq status");
	endtask : irq_check

	// Raise raw lock and time the qualified lock through the status register
	task automatic lock_up();
		@(posedge clk_sys_in);
		raw_lock_in <= 1'h1;
		t0 = cyc;
		got = 32'h0;
		for (int k = 0; k < 200 && got[0] !== 1'h1; k++) begin
			reg_rd(`ADDR_STATUS, got);
		end
		check_range("lock delay", m_cfg + 1, m_cfg + 12, cyc - t0);
	endtask : lock_up

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================
	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		miscompares++;
		tally_and_finish();
	end

	// ==========================================
	// Test sequence
	initial begin
		void'($urandom(32'had77));
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		foreach (rst_addr[i]) begin
			rd_check(rst_addr[i], rst_exp[i], "reset value");
		end
		// Every pin and level, clamped and random counts, each mask value
		for (int i = 0; i < 8; i++) begin
			m_cfg = (cfg_tab[i] == 0) ? $urandom_range(255, 17) : cfg_tab[i];
			reg_wr(`ADDR_LOCKCFG, m_cfg);
			m_cfg = (m_cfg < 16) ? 16 : (m_cfg > 256) ? 256 : m_cfg;
			rd_check(`ADDR_LOCKCFG, m_cfg, "lock count");
			m_mask = i % 4;
			reg_wr(`ADDR_IRQ_MASK, m_mask);
			set_ctrl(((i % 4) << `CTRL_LOCK_PIN_LSB) | ((i / 4) << `CTRL_LOCK_POL_BIT));
			pin_exp = (i < 4) ? (4'h1 << (i % 4)) : ~(4'h1 << (i % 4));
			lock_up();
			repeat (2) @(posedge clk_sys_in);
			#1;
			check_word("lock pin", {28'h0, pin_exp}, {28'h0, user_pin_out});
			m_irq = 1;
			irq_check();
			@(posedge clk_sys_in);
			raw_lock_in <= 1'h0;
			repeat (4) @(posedge clk_sys_in);
			#1;
			check_word("lock drop", {28'h0, pin_exp ^ (4'h1 << (i % 4))},
				{28'h0, user_pin_out});
			m_irq = 3;
			irq_check();
			reg_wr(`ADDR_IRQ_STAT, 3);
			m_irq = 0;
			repeat (2) @(posedge clk_sys_in);
			#1;
			irq_check();
		end
		// PLL reset, then bypass entry, each throw away qualification progress
		for (int j = 0; j < 3; j++) begin
			lock_up();
			if (j < 2) begin
				set_ctrl(m_ctrl | (1 << ((j == 1) ? `CTRL_BYPASS_BIT : `CTRL_PLL_RST_BIT)));
				rd_check(`ADDR_STATUS, {30'h0, j == 1, 1'h0}, "lock cleared");
				set_ctrl(m_ctrl & 32'h0000_3000);
			end
		end
		// Pin-selected bypass overrides the register bit
		for (int p = 0; p < 4; p++) begin
			set_ctrl((1 << `CTRL_BYP_PIN_EN_BIT) | (p % 2));
			@(posedge clk_sys_in);
			bypass_req <= (p > 1);
			repeat (6) @(posedge clk_sys_in);
			#1;
			check_word("bypass pin", {31'h0, p > 1}, {31'h0, bypass_out});
		end
		@(posedge clk_sys_in);
		bypass_req <= 1'h0;
		// Every mix of bypass, coarse taps and feedback path, tap set to m % 4, raw lock high
		for (int m = 0; m < 8; m++) begin
			m_skew = $urandom_range(255, 0);
			reg_wr(`ADDR_SKEW, m_skew);
			set_ctrl((m % 2) | ((m / 2 % 2) << `CTRL_COARSE_BIT) | ((m / 4) << `CTRL_EXT_FB_BIT)
				| ((m % 4) << `CTRL_FB_SEL_LSB));
			byp = m % 2;
			ext = m / 4;
			repeat (8) @(posedge clk_sys_in);
			base = edge_cnt;
			repeat (400) @(posedge clk_sys_in);
			#1;
			src = byp ? edge_cnt[0] - base[0] : edge_cnt[1] - base[1];
			for (int k = 0; k < 4; k++) begin
				r = ((m / 2 % 2) ? 4 : 2) << k;
				check_range("divider", src - r, src + r,
					(edge_cnt[k + 2] - base[k + 2]) * r);
			end
			r = ext ? 0 : m % 4 + 2;
			check_range("feedback", edge_cnt[r] - base[r] - 2, edge_cnt[r] - base[r] + 2,
				edge_cnt[6] - base[6]);
			check_word("skew", m_skew & (byp ? 32'hf0 : 32'hff) & (ext ? 32'hff : 32'h0f),
				{24'h0, fb_skew_out});
			check_word("fb path", {31'h0, ext == 1}, {31'h0, fb_is_ext_out});
			rd_check(`ADDR_STATUS, {29'h0, ext == 1, byp == 1, byp == 0}, "status");
			rd_check(`ADDR_CTRL, m_ctrl, "control");
		end
		tally_and_finish();
	end
endmodule : test_pll_ctrl_top
